/* common/pin_match_cfg.svh */
`ifndef PIN_MATCH_CFG_SVH
`define PIN_MATCH_CFG_SVH

// Register byte offsets
`define PM_OFF_MODE 12'h000
`define PM_OFF_ENR 12'h004
`define PM_OFF_ENR_SET 12'h008
`define PM_OFF_ENR_CLR 12'h00c
`define PM_OFF_ENF 12'h010
`define PM_OFF_ENF_SET 12'h014
`define PM_OFF_ENF_CLR 12'h018
`define PM_OFF_RISE 12'h01c
`define PM_OFF_FALL 12'h020
`define PM_OFF_STATUS 12'h024
`define PM_OFF_CTRL 12'h028
`define PM_OFF_SRC 12'h02c
`define PM_OFF_CFG 12'h030

// Reset values
`define PM_RST_BYTE 8'h00
`define PM_RST_WORD 32'h0000_0000

// Match control fields
`define PM_CTRL_SEL_BIT 0
`define PM_CTRL_RECEIVE_EVENT_OUT_BIT 1

// Slice layout: source 3 bits per slice from bit 0,
// configuration end-of-term flags in 6:0, condition 3 bits per slice from bit 8
`define PM_SRC_W 3
`define PM_CFG_COND_LSB 8
`define PM_COND_W 3

`endif

/* common/pin_match_pkg.sv */
package pin_match_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_IN = 8;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef enum logic [2:0] {
    COND_ALWAYS = 3'h0,
    COND_HIGH = 3'h1,
    COND_LOW = 3'h2,
    COND_RISE = 3'h3,
    COND_FALL = 3'h4,
    COND_NEVER = 3'h7
  } slice_cond_t;

endpackage : pin_match_pkg

/* rtl/pin_sync.sv */
`timescale 1ns/10ps
// Three-stage synchroniser; output follows once stages two and three agree
module pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;
  logic [WIDTH-1:0] agree;

  assign agree = ~(stage2_r ^ stage3_r);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stage1_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
      sync_out <= '0;
    end
    else if (ce)
    begin
      stage1_r <= async_in;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      sync_out <= (stage2_r & agree) | (sync_out & ~agree);
    end
  end

endmodule : pin_sync

/* rtl/match_slice.sv */
`timescale 1ns/10ps
// One literal of a product term
module match_slice (
  input wire pin_match_pkg::slice_cond_t cond,
  input wire logic level,
  input wire logic rise,
  input wire logic fall,
  input wire logic chain_in,
  input wire logic last,
  output logic term_out,
  output logic req
);

  logic literal;

  assign literal = (cond == pin_match_pkg::COND_ALWAYS) ? 1'b1 :
                   (cond == pin_match_pkg::COND_HIGH) ? level :
                   (cond == pin_match_pkg::COND_LOW) ? ~level :
                   (cond == pin_match_pkg::COND_RISE) ? rise :
                   (cond == pin_match_pkg::COND_FALL) ? fall : 1'b0;
  assign term_out = chain_in & literal;
  assign req = term_out & last;

endmodule : match_slice

/* rtl/pin_interrupt_pattern_match.sv */
// Operation
// - Selected pins sampled whatever their routed function
// - Eight separate interrupt request outputs
// - Pin requests from rising, falling or level
// - Continuous match, one request per matched term
// - Enabled receive event on any term match
// - Same match signal drives pattern output pin
// - Control bit picks pin or match requests
// - Receive event usable while pin interrupts selected
// - Only pin interrupts drive the wake request
// - Eight chained bit slices, one literal each
// - Only a term's last slice raises request
// - Slice tests high, low, rising or falling edge
// - Mode bits 7:0, one selects level, reset zero
// - Rise enable bit covers rising or level
// - Fall enable bit gives active level in level mode
// - Set register writes ones into rise enable
// - Clear register writes ones out of enable
// - Zero fall bit: no falling edge, or low active
`timescale 1ns/10ps
`include "pin_match_cfg.svh"
module pin_interrupt_pattern_match (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire pin_match_pkg::reg_req_t bus_req,
  output logic [31:0] rdata,
  input wire logic [7:0] pin_in,
  output logic [7:0] irq_out,
  output logic receive_event_out,
  output logic pattern_match_out,
  output logic wake_out
);

  localparam int unsigned N = pin_match_pkg::NUM_IN;

  logic [7:0] lvl;
  logic [7:0] lvl_prev_r;
  logic [7:0] rise_pulse;
  logic [7:0] fall_pulse;
  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  logic [7:0] enr_r;
  logic [7:0] enr_nxt;
  logic [7:0] enf_r;
  logic [7:0] enf_nxt;
  logic [7:0] rise_r;
  logic [7:0] rise_nxt;
  logic [7:0] fall_r;
  logic [7:0] fall_nxt;
  logic [1:0] ctrl_r;
  logic [1:0] ctrl_nxt;
  logic [23:0] src_r;
  logic [23:0] src_nxt;
  logic [31:0] cfg_r;
  logic [31:0] cfg_nxt;
  logic [7:0] wbyte;
  logic [7:0] rise_clr;
  logic [7:0] fall_clr;
  logic [7:0] edge_req;
  logic [7:0] level_req;
  logic [7:0] pin_req;
  logic [7:0] slice_req;
  logic [7:0] slice_term;
  logic [7:0] slice_last;
  logic [7:0] slice_chain;
  logic [7:0] irq_nxt;
  logic any_match;
  logic pm_sel;
  logic receive_event_out_en;
  logic [31:0] rd_val;
  logic hit_mode;
  logic hit_enr;
  logic hit_enr_set;
  logic hit_enr_clr;
  logic hit_enf;
  logic hit_enf_set;
  logic hit_enf_clr;
  logic hit_rise;
  logic hit_fall;
  logic hit_status;
  logic hit_ctrl;
  logic hit_src;
  logic hit_cfg;

  // Pins cross into the clock domain first
  pin_sync #(
    .WIDTH(N)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .async_in(pin_in),
    .sync_out(lvl)
  );

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      lvl_prev_r <= `PM_RST_BYTE;
    else if (ce)
      lvl_prev_r <= lvl;
  end

  assign rise_pulse = lvl & ~lvl_prev_r;
  assign fall_pulse = ~lvl & lvl_prev_r;

  // Write decode
  assign wbyte = bus_req.wdata[7:0];
  assign hit_mode = bus_req.wr && (bus_req.addr == `PM_OFF_MODE);
  assign hit_enr = bus_req.wr && (bus_req.addr == `PM_OFF_ENR);
  assign hit_enr_set = bus_req.wr && (bus_req.addr == `PM_OFF_ENR_SET);
  assign hit_enr_clr = bus_req.wr && (bus_req.addr == `PM_OFF_ENR_CLR);
  assign hit_enf = bus_req.wr && (bus_req.addr == `PM_OFF_ENF);
  assign hit_enf_set = bus_req.wr && (bus_req.addr == `PM_OFF_ENF_SET);
  assign hit_enf_clr = bus_req.wr && (bus_req.addr == `PM_OFF_ENF_CLR);
  assign hit_rise = bus_req.wr && (bus_req.addr == `PM_OFF_RISE);
  assign hit_fall = bus_req.wr && (bus_req.addr == `PM_OFF_FALL);
  assign hit_status = bus_req.wr && (bus_req.addr == `PM_OFF_STATUS);
  assign hit_ctrl = bus_req.wr && (bus_req.addr == `PM_OFF_CTRL);
  assign hit_src = bus_req.wr && (bus_req.addr == `PM_OFF_SRC);
  assign hit_cfg = bus_req.wr && (bus_req.addr == `PM_OFF_CFG);

  assign mode_nxt = hit_mode ? wbyte : mode_r;
  assign enr_nxt = hit_enr ? wbyte :
                   hit_enr_set ? (enr_r | wbyte) :
                   hit_enr_clr ? (enr_r & ~wbyte) : enr_r;
  // Status write toggles active level of level-mode inputs
  assign enf_nxt = hit_enf ? wbyte :
                   hit_enf_set ? (enf_r | wbyte) :
                   hit_enf_clr ? (enf_r & ~wbyte) :
                   hit_status ? (enf_r ^ (wbyte & mode_r)) : enf_r;

  // Status write clears edge flags of edge-mode inputs; new edges win
  assign rise_clr = hit_rise ? wbyte : hit_status ? (wbyte & ~mode_r) : 8'h00;
  assign fall_clr = hit_fall ? wbyte : hit_status ? (wbyte & ~mode_r) : 8'h00;
  assign rise_nxt = (rise_r & ~rise_clr) | rise_pulse;
  assign fall_nxt = (fall_r & ~fall_clr) | fall_pulse;

  assign ctrl_nxt = hit_ctrl ?
                    {bus_req.wdata[`PM_CTRL_RECEIVE_EVENT_OUT_BIT], bus_req.wdata[`PM_CTRL_SEL_BIT]} :
                    ctrl_r;
  assign src_nxt = hit_src ? bus_req.wdata[23:0] : src_r;
  assign cfg_nxt = hit_cfg ? bus_req.wdata : cfg_r;
  assign pm_sel = ctrl_r[0];
  assign receive_event_out_en = ctrl_r[1];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_r <= `PM_RST_BYTE;
      enr_r <= `PM_RST_BYTE;
      enf_r <= `PM_RST_BYTE;
      rise_r <= `PM_RST_BYTE;
      fall_r <= `PM_RST_BYTE;
    end
    else if (ce)
    begin
      mode_r <= mode_nxt;
      enr_r <= enr_nxt;
      enf_r <= enf_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_r <= 2'h0;
      src_r <= 24'h00_0000;
      cfg_r <= `PM_RST_WORD;
    end
    else if (ce)
    begin
      ctrl_r <= ctrl_nxt;
      src_r <= src_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  // Pin interrupt requests
  assign edge_req = (rise_r & enr_r) | (fall_r & enf_r);
  assign level_req = enr_r & ~(lvl ^ enf_r);
  assign pin_req = (~mode_r & edge_req) | (mode_r & level_req);

  // Chained bit slices; slice 7 always closes a term
  assign slice_last = {1'b1, cfg_r[6:0]};

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++)
    begin : g_slice
      logic [2:0] sel;
      logic chain_in;
      assign sel = src_r[gi*`PM_SRC_W +: `PM_SRC_W];
      if (gi == 0)
      begin : g_first
        assign chain_in = 1'b1;
      end
      else
      begin : g_next
        assign chain_in = slice_last[gi-1] | slice_term[gi-1];
      end
      assign slice_chain[gi] = chain_in;
      match_slice u_slice (
        .cond(pin_match_pkg::slice_cond_t'(cfg_r[`PM_CFG_COND_LSB + gi*`PM_COND_W +:
                                                  `PM_COND_W])),
        .level(lvl[sel]),
        .rise(rise_pulse[sel]),
        .fall(fall_pulse[sel]),
        .chain_in(chain_in),
        .last(slice_last[gi]),
        .term_out(slice_term[gi]),
        .req(slice_req[gi])
      );
    end
  endgenerate

  assign any_match = |slice_req;
  assign irq_nxt = pm_sel ? slice_req : pin_req;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_out <= `PM_RST_BYTE;
      receive_event_out <= 1'b0;
      pattern_match_out <= 1'b0;
      wake_out <= 1'b0;
    end
    else if (ce)
    begin
      irq_out <= irq_nxt;
      receive_event_out <= receive_event_out_en & any_match;
      pattern_match_out <= any_match;
      wake_out <= ~pm_sel & (|pin_req);
    end
  end

  // Read mux; unmapped and write-only offsets read zero
  assign rd_val = (bus_req.addr == `PM_OFF_MODE) ? {24'h00_0000, mode_r} :
                  (bus_req.addr == `PM_OFF_ENR) ? {24'h00_0000, enr_r} :
                  (bus_req.addr == `PM_OFF_ENF) ? {24'h00_0000, enf_r} :
                  (bus_req.addr == `PM_OFF_RISE) ? {24'h00_0000, rise_r} :
                  (bus_req.addr == `PM_OFF_FALL) ? {24'h00_0000, fall_r} :
                  (bus_req.addr == `PM_OFF_STATUS) ? {24'h00_0000, pin_req} :
                  (bus_req.addr == `PM_OFF_CTRL) ? {30'h0000_0000, ctrl_r} :
                  (bus_req.addr == `PM_OFF_SRC) ? {8'h00, src_r} :
                  (bus_req.addr == `PM_OFF_CFG) ? cfg_r : `PM_RST_WORD;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata <= `PM_RST_WORD;
    else if (ce)
      rdata <= bus_req.rd ? rd_val : `PM_RST_WORD;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_rise_capture: assert property (
    ce |=> ((rise_r & $past(rise_pulse)) == $past(rise_pulse)))
    else $error("rising edge not captured");

  a_fall_capture: assert property (
    ce |=> ((fall_r & $past(fall_pulse)) == $past(fall_pulse)))
    else $error("falling edge not captured");

  a_irq_source_sel: assert property (
    ce |=> (irq_out == ($past(pm_sel) ? $past(slice_req) : $past(pin_req))))
    else $error("request lines from wrong source");

  a_event_out: assert property (
    ce |=> (receive_event_out == ($past(receive_event_out_en) && (|$past(slice_req)))))
    else $error("receive event mismatch");

  a_event_pin_tie: assert property (
    receive_event_out |-> pattern_match_out)
    else $error("event without pattern pin");

  a_enable_set: assert property (
    ce && hit_enr_set |=> ((enr_r & $past(wbyte)) == $past(wbyte))
      && ((enr_r & ~$past(wbyte)) == ($past(enr_r) & ~$past(wbyte))))
    else $error("enable set wrong");

  a_enable_clear: assert property (
    ce && hit_enr_clr |=> ((enr_r & $past(wbyte)) == 8'h00)
      && ((enr_r & ~$past(wbyte)) == ($past(enr_r) & ~$past(wbyte))))
    else $error("enable clear wrong");

  a_level_active: assert property (
    ce && !pm_sel && mode_r[2] && enr_r[2] && (lvl[2] == enf_r[2]) |=> irq_out[2])
    else $error("level request missing");

  a_reserved_zero: assert property (
    ce && bus_req.rd && (bus_req.addr <= `PM_OFF_STATUS) |=> (rdata[31:8] == 24'h00_0000))
    else $error("reserved bits not zero");

  a_last_slice_only: assert property (
    (slice_req & ~slice_last) == 8'h00)
    else $error("request from inner slice");

  a_wake_pin_only: assert property (
    ce && pm_sel |=> !wake_out)
    else $error("wake from pattern match");

  a_level_inactive: assert property (
    ce && !pm_sel && mode_r[2] && (lvl[2] != enf_r[2]) |=> !irq_out[2])
    else $error("level request at wrong level");

  a_disabled_quiet: assert property (
    ce && !pm_sel && (enr_r == 8'h00) && ((enf_r & ~mode_r) == 8'h00)
      |=> (irq_out == 8'h00))
    else $error("request while all disabled");

  a_match_pin_out: assert property (
    ce |=> (pattern_match_out == (|$past(slice_req))))
    else $error("pattern pin mismatch");

  a_rise_sticky: assert property (
    ce && !hit_rise && !hit_status |=> ((rise_r & $past(rise_r)) == $past(rise_r)))
    else $error("edge flag lost");

  a_wake_follows: assert property (
    ce && !pm_sel |=> (wake_out == (|$past(pin_req))))
    else $error("wake request mismatch");

  a_mode_write: assert property (
    ce && hit_mode |=> (mode_r == $past(wbyte)))
    else $error("mode write lost");

  c_pin_edge_irq: cover property (ce && !pm_sel && |rise_pulse ##[1:4] |irq_out);
  c_match_event: cover property (ce && receive_event_out_en && any_match ##1 receive_event_out);
  c_event_with_pins: cover property (ce && !pm_sel && receive_event_out_en && any_match);
  c_chain_term: cover property (slice_chain[2] && !slice_last[1] && slice_req[2]);

endmodule : pin_interrupt_pattern_match

/* verif/irq_sink_model.sv */
`timescale 1ns/10ps
// Processor side: latches each request line and counts event pulses
module irq_sink_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic [7:0] irq_in,
  input wire logic event_in,
  output logic [7:0] seen_r,
  output logic [7:0] event_cnt_r
);
  logic event_d_r;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      seen_r <= 8'h00;
      event_cnt_r <= 8'h00;
      event_d_r <= 1'b0;
    end
    else
    begin
      event_d_r <= event_in;
      // One line per request, so short pulses are not lost
      seen_r <= clr ? 8'h00 : (seen_r | irq_in);
      if (clr)
        event_cnt_r <= 8'h00;
      else if (event_in && !event_d_r)
        event_cnt_r <= event_cnt_r + 8'h01;
    end
  end
endmodule : irq_sink_model

/* verif/pin_interrupt_pattern_match_test.sv */
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module pin_interrupt_pattern_match_test;
  logic clk;
  logic rstn;
  logic clr;
  logic ce;
  pin_match_pkg::reg_req_t req;
  logic [31:0] rdata;
  logic [7:0] pin_in;
  logic [7:0] irq_out;
  logic receive_event_out;
  logic pattern_match_out;
  logic wake_out;
  logic [7:0] seen;
  logic [7:0] ev_cnt;
  int err_total;
  int n_checks;
  int cycles;
  logic [11:0] rst_addr [7] = '{12'h000, 12'h004, 12'h010, 12'h01c, 12'h020, 12'h024, 12'h028};

  pin_interrupt_pattern_match u_pin_interrupt_pattern_match (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .bus_req(req),
    .rdata(rdata),
    .pin_in(pin_in),
    .irq_out(irq_out),
    .receive_event_out(receive_event_out),
    .pattern_match_out(pattern_match_out),
    .wake_out(wake_out)
  );

  irq_sink_model u_irq_sink_model (
    .clk(clk),
    .rstn(rstn),
    .clr(clr),
    .irq_in(irq_out),
    .event_in(receive_event_out),
    .seen_r(seen),
    .event_cnt_r(ev_cnt)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic wrap_up;
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      wrap_up();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    `CHK(rdata, exp)
  endtask : rd

  initial
  begin
    err_total = 0;
    n_checks = 0;
    cycles = 0;
    rstn = 1'b0;
    clr = 1'b0;
    ce = 1'b1;
    req = '0;
    pin_in = 8'h00;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    foreach (rst_addr[i]) rd(rst_addr[i], 32'h0000_0000);
    rd(12'h040, 32'h0000_0000);
    wr(12'h000, 32'hffff_ffff);
    rd(12'h000, 32'h0000_00ff);
    wr(12'h000, 32'h0000_0000);
    wr(12'h004, 32'h0000_0005);
    wr(12'h008, 32'h0000_000a);
    rd(12'h004, 32'h0000_000f);
    rd(12'h008, 32'h0000_0000);
    wr(12'h00c, 32'h0000_0003);
    rd(12'h004, 32'h0000_000c);
    wr(12'h004, 32'h0000_0001);
    wr(12'h014, 32'h0000_0002);
    rd(12'h010, 32'h0000_0002);
    // Edge mode: pin 0 rising enabled, pin 1 falling enabled
    @(posedge clk) pin_in <= 8'h03;
    tick(7);
    `CHK(irq_out, 8'h01)
    `CHK(wake_out, 1'b1)
    rd(12'h024, 32'h0000_0001);
    @(posedge clk) pin_in <= 8'h00;
    tick(7);
    `CHK(irq_out, 8'h03)
    wr(12'h01c, 32'h0000_0001);
    rd(12'h01c, 32'h0000_0002);
    `CHK(irq_out, 8'h02)
    wr(12'h024, 32'h0000_0003);
    tick(2);
    `CHK(irq_out, 8'h00)
    rd(12'h020, 32'h0000_0000);
    wr(12'h00c, 32'h0000_00ff);
    wr(12'h018, 32'h0000_00ff);
    rd(12'h010, 32'h0000_0000);
    // Level mode on pin 2, active level from fall enable bit
    wr(12'h000, 32'h0000_0004);
    wr(12'h008, 32'h0000_0004);
    tick(5);
    `CHK(irq_out, 8'h04)
    wr(12'h014, 32'h0000_0004);
    tick(3);
    `CHK(irq_out, 8'h00)
    @(posedge clk) pin_in <= 8'h04;
    tick(6);
    `CHK(irq_out, 8'h04)
    // Status write flips the active level to low
    wr(12'h024, 32'h0000_0004);
    rd(12'h010, 32'h0000_0000);
    `CHK(irq_out, 8'h00)
    wr(12'h00c, 32'h0000_00ff);
    wr(12'h000, 32'h0000_0000);
    @(posedge clk) pin_in <= 8'h00;
    // Term A: in0 high, in1 low ends at slice 1; term B: in2 rising at slice 2
    wr(12'h02c, 32'h00fa_c688);
    wr(12'h030, 32'hffee_d106);
    rd(12'h02c, 32'h00fa_c688);
    rd(12'h030, 32'hffee_d106);
    @(posedge clk) pin_in <= 8'h01;
    wr(12'h028, 32'h0000_0003);
    tick(7);
    `CHK(irq_out, 8'h02)
    `CHK(receive_event_out, 1'b1)
    `CHK(pattern_match_out, 1'b1)
    `CHK(wake_out, 1'b0)
    @(posedge clk) pin_in <= 8'h03;
    tick(7);
    `CHK(irq_out, 8'h00)
    `CHK(pattern_match_out, 1'b0)
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    @(posedge clk) pin_in <= 8'h07;
    tick(8);
    `CHK(seen, 8'h04)
    `CHK(ev_cnt, 8'h01)
    // Pin mode selected, event still enabled
    wr(12'h028, 32'h0000_0002);
    @(posedge clk) pin_in <= 8'h01;
    tick(7);
    `CHK(receive_event_out, 1'b1)
    `CHK(irq_out, 8'h00)
    wr(12'h028, 32'h0000_0000);
    tick(3);
    `CHK(receive_event_out, 1'b0)
    `CHK(pattern_match_out, 1'b1)
    // Writes while frozen are not taken
    @(posedge clk) ce <= 1'b0;
    wr(12'h000, 32'h0000_00ff);
    @(posedge clk) ce <= 1'b1;
    rd(12'h000, 32'h0000_0000);
    wrap_up();
  end
endmodule : pin_interrupt_pattern_match_test
